//--- src/ddr2_cmd_consts.svh
// Function
// - activate takes bank from bank_select and row from fourteen address bits.
// - read/write address gives start column and auto-precharge choice.
// - mode register may be rewritten later only while all banks precharged.
// - mode bits 2..0 select burst length, four or eight.
// - mode bit 3 picks sequential or interleaved order for both lengths.
// - mode bits 6..4 set read latency in clocks from read to data.
// - two low bank bits of mode write pick main or extended registers.
// - command decoded from clock enable now and one cycle earlier.
// - power-down on enable fall with no-op; exit on rise with no-op.
// - high byte-mask blocks its lane's write data; lanes independent.
// - row strobe low, column high: activate if write high, precharge if low.
// - row high, column low: read if write strobe high, write if low.
// - commands with enable high both cycles ignored while chip select sampled high; power-down entry and exits still decoded.
`ifndef DDR2_CMD_CONSTS_SVH
`define DDR2_CMD_CONSTS_SVH
`define BL_FOUR        3'h2
`define BL_EIGHT       3'h3
`define MR_BL_LSB      0
`define MR_ORDER_BIT   3
`define MR_CL_LSB      4
`define MR_DLLRST_BIT  8
`define MR_WR_LSB      9
`define AP_BIT         10
`define SEL_MAIN       2'h0
`define SEL_EXT1       2'h1
`define SEL_EXT2       2'h2
`define SEL_EXT3       2'h3
`endif

//--- src/ddr2_cmd_decode.sv
`timescale 1ns/1ps
`include "ddr2_cmd_consts.svh"
module ddr2_cmd_decode #(
  parameter int BANKS = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire ddr2_cmd_pkg::pins_t   pins_i,
  input  wire logic                  low_byte_mask_i,
  input  wire logic                  high_byte_mask_i,
  input  wire logic [15:0]           write_data_i,
  output logic [3:0]                 cmd_o,
  output ddr2_cmd_pkg::access_t      access_o,
  output ddr2_cmd_pkg::mode_t        mode_o,
  output logic [13:0]                ext1_o,
  output logic [13:0]                ext2_o,
  output logic [13:0]                ext3_o,
  output logic [BANKS-1:0]           bank_open_o,
  output logic [1:0]                 power_state_o,
  output logic                       burst_is_eight_o,
  output logic [15:0]                masked_data_o,
  output logic [1:0]                 lane_write_o
);
  import ddr2_cmd_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  pins_t        pins_meta_reg;
  pins_t        pins_reg;
  logic [17:0]  dat_meta_reg;
  logic [17:0]  dat_reg;
  logic         cke_prev_reg;
  always_ff @(posedge clk_i) begin
    pins_meta_reg <= pins_i;
    pins_reg      <= pins_meta_reg;
    dat_meta_reg  <= {high_byte_mask_i, low_byte_mask_i, write_data_i};
    dat_reg       <= dat_meta_reg;
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cke_prev_reg <= 1'b0;
    end else begin
      cke_prev_reg <= pins_reg.cke;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  cmd_t cmd_next;
  logic nop_or_desel;
  assign nop_or_desel = pins_reg.cs_n | (pins_reg.ras_n & pins_reg.cas_n & pins_reg.we_n);
  always_comb begin
    cmd_next = CMD_NONE;
    case ({cke_prev_reg, pins_reg.cke})
      2'b11: begin
        if (!pins_reg.cs_n) begin
          case ({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n})
            3'b011:  cmd_next = CMD_ACT;
            3'b010:  cmd_next = CMD_PRE;
            3'b101:  cmd_next = CMD_READ;
            3'b100:  cmd_next = CMD_WRITE;
            3'b000:  cmd_next = CMD_MODE;
            3'b001:  cmd_next = CMD_REFRESH;
            default: cmd_next = CMD_NONE;
          endcase
        end
      end
      2'b10: begin
        if (!pins_reg.cs_n && {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} == 3'b001) begin
          cmd_next = CMD_SR_ENTER;
        end else if (nop_or_desel) begin
          cmd_next = CMD_PD_ENTER;
        end
      end
      2'b01: begin
        if (nop_or_desel) begin
          cmd_next = (power_state_o == PWR_SREF) ? CMD_SR_EXIT : CMD_PD_EXIT;
        end
      end
      default: cmd_next = CMD_NONE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_o <= CMD_NONE;
    end else begin
      cmd_o <= cmd_next;
    end
  end

  // ----------------------------------------
  // bank state and addressing
  // ----------------------------------------
  logic all_idle;
  assign all_idle = ~|bank_open_o;
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          bank_open_o[b] <= 1'b0;
        end else if (cmd_next == CMD_ACT && pins_reg.bank_select == 3'(b)) begin
          bank_open_o[b] <= 1'b1;
        end else if (cmd_next == CMD_PRE
                     && (pins_reg.addr[`AP_BIT] || pins_reg.bank_select == 3'(b))) begin
          bank_open_o[b] <= 1'b0;
        end else if ((cmd_next == CMD_READ || cmd_next == CMD_WRITE)
                     && pins_reg.addr[`AP_BIT] && pins_reg.bank_select == 3'(b)) begin
          bank_open_o[b] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      access_o <= '0;
    end else if (cmd_next == CMD_ACT) begin
      access_o.bank <= pins_reg.bank_select;
      access_o.row  <= pins_reg.addr;
    end else if (cmd_next == CMD_READ || cmd_next == CMD_WRITE) begin
      access_o.bank     <= pins_reg.bank_select;
      access_o.column   <= pins_reg.addr[9:0];
      access_o.auto_pre <= pins_reg.addr[`AP_BIT];
    end
  end

  // ----------------------------------------
  // mode registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_o <= '0;
      ext1_o <= '0;
      ext2_o <= '0;
      ext3_o <= '0;
    end else if (cmd_next == CMD_MODE && all_idle) begin
      case (pins_reg.bank_select[1:0])
        `SEL_MAIN: begin
          mode_o.burst_len      <= pins_reg.addr[`MR_BL_LSB +: 3];
          mode_o.interleaved    <= pins_reg.addr[`MR_ORDER_BIT];
          mode_o.read_latency   <= pins_reg.addr[`MR_CL_LSB +: 3];
          mode_o.dll_reset      <= pins_reg.addr[`MR_DLLRST_BIT];
          mode_o.write_recovery <= pins_reg.addr[`MR_WR_LSB +: 3];
        end
        `SEL_EXT1: ext1_o <= pins_reg.addr;
        `SEL_EXT2: ext2_o <= pins_reg.addr;
        `SEL_EXT3: ext3_o <= pins_reg.addr;
        default:   ext3_o <= ext3_o;
      endcase
    end
  end
  assign burst_is_eight_o = (mode_o.burst_len == `BL_EIGHT);

  // ----------------------------------------
  // power state
  // ----------------------------------------
  pwr_t pwr_reg;
  assign power_state_o = pwr_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwr_reg <= PWR_ON;
    end else begin
      case (cmd_next)
        CMD_SR_ENTER: pwr_reg <= PWR_SREF;
        CMD_PD_ENTER: pwr_reg <= PWR_DOWN;
        CMD_SR_EXIT,
        CMD_PD_EXIT:  pwr_reg <= PWR_ON;
        default:      pwr_reg <= pwr_reg;
      endcase
    end
  end

  // ----------------------------------------
  // write byte masking
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      masked_data_o <= '0;
      lane_write_o  <= '0;
    end else begin
      lane_write_o  <= ~dat_reg[17:16];
      masked_data_o <= {dat_reg[17] ? 8'h00 : dat_reg[15:8],
                        dat_reg[16] ? 8'h00 : dat_reg[7:0]};
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_cs_masks: assert property (@(posedge clk_i) disable iff (reset_i)
    pins_reg.cs_n && cke_prev_reg && pins_reg.cke |=> cmd_o == CMD_NONE)
    else $error("command taken with chip select high");
  chk_act_row: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_next == CMD_ACT |=> access_o.row == $past(pins_reg.addr) && bank_open_o[access_o.bank])
    else $error("activate row or bank not captured");
  chk_ap_close: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_next == CMD_READ && pins_reg.addr[`AP_BIT] |=> !bank_open_o[access_o.bank] && access_o.auto_pre)
    else $error("auto precharge not applied");
  chk_mode_busy: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_next == CMD_MODE && !all_idle |=> $stable(mode_o))
    else $error("mode written with open bank");
  chk_mode_sel: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_next == CMD_MODE && all_idle && pins_reg.bank_select[1:0] == `SEL_EXT2
    |=> ext2_o == $past(pins_reg.addr) && $stable(mode_o))
    else $error("extended register two not selected");
  chk_sref_enter: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_next == CMD_SR_ENTER |=> power_state_o == PWR_SREF)
    else $error("self refresh not entered");
  chk_pd_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
    power_state_o == PWR_DOWN && cmd_next == CMD_PD_EXIT |=> power_state_o == PWR_ON)
    else $error("power-down not exited");
  chk_lane_mask: assert property (@(posedge clk_i) disable iff (reset_i)
    dat_reg[16] |=> masked_data_o[7:0] == 8'h00 && !lane_write_o[0])
    else $error("masked low lane written");
  chk_burst_len: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_next == CMD_MODE && all_idle && pins_reg.bank_select[1:0] == `SEL_MAIN
    && pins_reg.addr[2:0] == `BL_EIGHT |=> burst_is_eight_o)
    else $error("burst length eight not selected");
  chk_order_bit: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_next == CMD_MODE && all_idle && pins_reg.bank_select[1:0] == `SEL_MAIN
    |=> mode_o.interleaved == $past(pins_reg.addr[3]))
    else $error("order bit not stored");
  chk_latency: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_next == CMD_MODE && all_idle && pins_reg.bank_select[1:0] == `SEL_MAIN
    |=> mode_o.read_latency == $past(pins_reg.addr[6:4]))
    else $error("read latency not stored");
endmodule

//--- src/ddr2_cmd_pkg.sv
package ddr2_cmd_pkg;
  typedef enum logic [3:0] {
    CMD_NONE     = 4'h0,
    CMD_ACT      = 4'h1,
    CMD_PRE      = 4'h2,
    CMD_READ     = 4'h3,
    CMD_WRITE    = 4'h4,
    CMD_MODE     = 4'h5,
    CMD_REFRESH  = 4'h6,
    CMD_SR_ENTER = 4'h7,
    CMD_SR_EXIT  = 4'h8,
    CMD_PD_ENTER = 4'h9,
    CMD_PD_EXIT  = 4'ha
  } cmd_t;
  typedef enum logic [1:0] {
    PWR_ON    = 2'h0,
    PWR_DOWN  = 2'h1,
    PWR_SREF  = 2'h2
  } pwr_t;
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [2:0]  bank_select;
    logic [13:0] addr;
  } pins_t;
  typedef struct packed {
    logic [2:0] burst_len;
    logic       interleaved;
    logic [2:0] read_latency;
    logic       dll_reset;
    logic [2:0] write_recovery;
  } mode_t;
  typedef struct packed {
    logic [2:0]  bank;
    logic [13:0] row;
    logic [9:0]  column;
    logic        auto_pre;
  } access_t;
endpackage

//--- tb/ddr2_ctrl_model.sv
`timescale 1ns/1ps
module ddr2_ctrl_model (
  input  wire logic           clk_i,
  output ddr2_cmd_pkg::pins_t pins_o
);
  import ddr2_cmd_pkg::*;
  initial begin
    pins_o = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 14'h0000};
  end
  // ----------------------------------------
  // one command for one edge, then deselect
  // ----------------------------------------
  task automatic drive(input logic [3:0] c, input logic ck, input logic [2:0] ba, input logic [13:0] a);
    @(posedge clk_i);
    #1;
    pins_o = '{c[3], c[2], c[1], c[0], ck, ba, a};
    @(posedge clk_i);
    #1;
    pins_o = '{1'b1, 1'b1, 1'b1, 1'b1, ck, ~ba, ~a};
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import ddr2_cmd_pkg::*;
  localparam logic [3:0] C_ACT = 4'h3, C_PRE = 4'h2, C_RD = 4'h5, C_WR = 4'h4;
  localparam logic [3:0] C_MODE = 4'h0, C_REF = 4'h1, C_NOP = 4'h7, C_DES = 4'hf;
  logic        clk_i;
  logic        reset_i;
  logic        low_byte_mask_i;
  logic        high_byte_mask_i;
  logic [15:0] write_data_i;
  pins_t       pins;
  logic [3:0]  cmd_o;
  access_t     access_o;
  mode_t       mode_o;
  logic [13:0] ext1_o;
  logic [13:0] ext2_o;
  logic [13:0] ext3_o;
  logic [7:0]  bank_open_o;
  logic [1:0]  power_state_o;
  logic        burst_is_eight_o;
  logic [15:0] masked_data_o;
  logic [1:0]  lane_write_o;
  logic [13:0] a;
  int          err_total;
  int          n_compared;

  ddr2_ctrl_model u_ctrl (.clk_i(clk_i), .pins_o(pins));
  ddr2_cmd_decode #(.BANKS(8)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .pins_i(pins), .low_byte_mask_i(low_byte_mask_i),
    .high_byte_mask_i(high_byte_mask_i), .write_data_i(write_data_i), .cmd_o(cmd_o),
    .access_o(access_o), .mode_o(mode_o), .ext1_o(ext1_o), .ext2_o(ext2_o), .ext3_o(ext3_o),
    .bank_open_o(bank_open_o), .power_state_o(power_state_o), .burst_is_eight_o(burst_is_eight_o),
    .masked_data_o(masked_data_o), .lane_write_o(lane_write_o)
  );

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  // ----------------------------------------
  // compare, issue and verdict tasks
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cmd(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [3:0] c, input logic ck, input logic [2:0] ba, input logic [13:0] ad,
                       input logic [3:0] ec);
    u_ctrl.drive(c, ck, ba, ad);
    repeat (2) @(posedge clk_i);
    #1;
    if (ec != 4'hf) chk_cmd(cmd_o, ec);
  endtask
  task automatic summarize;
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #400us;
    err_total++;
    summarize();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    n_compared = 0;
    reset_i = 1'b1;
    low_byte_mask_i = 1'b0;
    high_byte_mask_i = 1'b0;
    write_data_i = 16'h5aa5;
    repeat (20) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    chk_val(bank_open_o, 32'h0);
    repeat (20000) @(posedge clk_i);
    u_ctrl.drive(C_NOP, 1'b1, 3'h0, 14'h0000);
    repeat (20) u_ctrl.drive(C_NOP, 1'b1, 3'h0, 14'h0000);
    issue(C_PRE, 1'b1, 3'h0, 14'h0400, CMD_PRE);
    issue(C_MODE, 1'b1, 3'h2, 14'h0080, CMD_MODE);
    chk_val(ext2_o, 32'h0080);
    issue(C_MODE, 1'b1, 3'h3, 14'h0000, CMD_MODE);
    chk_val(ext3_o, 32'h0);
    issue(C_MODE, 1'b1, 3'h1, 14'h0000, CMD_MODE);
    chk_val(ext1_o, 32'h0);
    issue(C_MODE, 1'b1, 3'h0, 14'h0132, CMD_MODE);
    chk_val(mode_o, {3'h2, 1'b0, 3'h3, 1'b1, 3'h0});
    issue(C_PRE, 1'b1, 3'h0, 14'h0400, CMD_PRE);
    repeat (2) issue(C_REF, 1'b1, 3'h0, 14'h0000, CMD_REFRESH);
    for (int i = 0; i < 4; i++) begin
      a = 14'h0a32 | {10'h000, i[1], 2'b00, i[0]};
      issue(C_MODE, 1'b1, 3'h0, a, CMD_MODE);
      chk_val(mode_o, {a[2:0], a[3], a[6:4], a[8], a[11:9]});
      chk_val(burst_is_eight_o, i[0]);
    end
    repeat (200) @(posedge clk_i);
    issue(C_MODE, 1'b1, 3'h1, 14'h0380, CMD_MODE);
    chk_val(ext1_o, 32'h0380);
    issue(C_MODE, 1'b1, 3'h1, 14'h0000, CMD_MODE);
    chk_val(ext1_o, 32'h0);
    issue(C_ACT, 1'b1, 3'h5, 14'h2abc, CMD_ACT);
    chk_val({access_o.bank, access_o.row, bank_open_o}, {3'h5, 14'h2abc, 8'h20});
    issue(C_MODE, 1'b1, 3'h0, 14'h0002, CMD_MODE);
    chk_val(mode_o, {a[2:0], a[3], a[6:4], a[8], a[11:9]});
    issue(C_RD, 1'b1, 3'h5, 14'h0555, CMD_READ);
    chk_val({access_o.bank, access_o.column, access_o.auto_pre, bank_open_o}, {3'h5, 10'h155, 1'b1, 8'h00});
    issue(C_ACT, 1'b1, 3'h5, 14'h2abc, CMD_ACT);
    chk_val(bank_open_o, 32'h20);
    for (int m = 1; m < 3; m++) begin
      low_byte_mask_i = m[0];
      high_byte_mask_i = m[1];
      issue(C_WR, 1'b1, 3'h5, 14'h0123, CMD_WRITE);
      chk_val({access_o.column, access_o.auto_pre}, {10'h123, 1'b0});
      chk_val(lane_write_o, {~m[1], ~m[0]});
      chk_val(masked_data_o, m[0] ? 16'h5a00 : 16'h00a5);
    end
    issue(4'hb, 1'b1, 3'h2, 14'h0100, CMD_NONE);
    chk_val(bank_open_o, 32'h20);
    issue(C_PRE, 1'b1, 3'h5, 14'h0000, CMD_PRE);
    chk_val(bank_open_o, 32'h0);
    issue(C_REF, 1'b0, 3'h0, 14'h0000, CMD_SR_ENTER);
    chk_val(power_state_o, 32'h2);
    issue(C_NOP, 1'b1, 3'h0, 14'h0000, CMD_SR_EXIT);
    chk_val(power_state_o, 32'h0);
    issue(C_NOP, 1'b0, 3'h0, 14'h0000, CMD_PD_ENTER);
    chk_val(power_state_o, 32'h1);
    issue(C_DES, 1'b1, 3'h0, 14'h0000, CMD_PD_EXIT);
    chk_val(power_state_o, 32'h0);
    summarize();
  end
endmodule
